// ===== design/interval_timer_pkg.sv
// package of constants for the legacy interval timer and its host end
// Summary of operation
// - three 16-bit counters, six modes each
// - counters step on gated ~1.193 MHz tick
// - counter 0 output drives system timer irq
// - written count loads one tick later
// - square wave: step by two, toggle, reload
// - host writes control word before count
// - format bits: low, high, or low-high
// - new count keeps programmed mode unchanged
// - host never splits two-byte count writes
// - command port: control, latch, read-back, bcd
// - mode 0: low, high at zero, stays
// - mode 1: low, high one tick at zero
// - mode 2: high, low one tick, reload
// - mode 3: high, toggle and reload each rollover
// - modes 4,5: high, low one tick at expiry
// - two-byte counts read twice, interleaving allowed
// - unlatched read may be indeterminate
// - latch freezes snapshot until read or reprogrammed
// - second latch before read is ignored
// - read-back latches count and status together
// - repeated latches without read are ignored
// - status read first, then count bytes
package interval_timer_pkg;
   localparam logic [7:0] counter0_count_port = 8'h40;
   localparam logic [7:0] timer_command_port = 8'h43;
   localparam int num_counters = 3;
   localparam int clk_hz = 20000000;
   localparam int tick_hz = 1193182;
   localparam int tick_div = (clk_hz + tick_hz / 2) / tick_hz; // about 17 clocks per tick
   // control word fields
   localparam int cw_sel_lsb = 6;
   localparam int cw_rw_lsb = 4;
   localparam int cw_mode_lsb = 1;
   localparam int cw_bcd_bit = 0;
   localparam logic [1:0] sel_readback = 2'h3;
   localparam logic [1:0] rw_latch = 2'h0;
   localparam logic [1:0] rw_low = 2'h1;
   localparam logic [1:0] rw_high = 2'h2;
   localparam logic [1:0] rw_both = 2'h3;
   // read-back fields: bit5 clear latches count, bit4 clear latches status
   localparam int rb_count_n_bit = 5;
   localparam int rb_status_n_bit = 4;
   localparam int rb_cnt0_bit = 1;
   // status byte
   localparam int st_out_bit = 7;
   localparam int st_null_bit = 6;
endpackage

// ===== design/interval_timer_if.sv
// byte port interface between host end and timer end
`timescale 1ns/10ps
`default_nettype none
interface interval_timer_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   modport timer (input addr, input wdata, input wr, input rd, output rdata);
   modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ===== design/interval_timer.sv
// legacy three-counter interval timer, device end
//
// The strobed register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module interval_timer (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // port access
   interval_timer_if.timer bus,
   // system
   input wire logic working_state,
   input wire logic [2:0] gate,
   output logic system_timer_irq,
   output logic [2:0] counter_out
);
   logic [4:0] div_reg;
   logic tick;
   // tick divider from crystal-derived clock, idle outside working state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 5'h00;
      end else if (!working_state) begin
         div_reg <= 5'h00;
      end else if (div_reg == 5'(interval_timer_pkg::tick_div - 1)) begin
         div_reg <= 5'h00;
      end else begin
         div_reg <= div_reg + 5'h01;
      end
   end
   assign tick = working_state && (div_reg == 5'(interval_timer_pkg::tick_div - 1));

   logic [7:0] rdata_reg;
   logic [2:0] rd_hit;
   logic [7:0] rbyte [3];
   logic is_cmd;
   assign is_cmd = bus.wr && bus.addr == interval_timer_pkg::timer_command_port;
   assign system_timer_irq = counter_out[0];

   // per-counter logic, one copy per counter
   genvar g;
   generate
      for (g = 0; g < interval_timer_pkg::num_counters; g++) begin : ch
         logic [2:0] mode_reg;
         logic [1:0] rw_reg;
         logic bcd_reg;
         logic [15:0] init_reg, cnt_reg, latch_reg;
         logic [7:0] status_reg;
         logic out_reg, null_reg, load_reg, armed_reg, wlow_reg, rlow_reg;
         logic cl_reg, sl_reg, gate_q;
         logic sel_port, cw_hit, cl_hit, rbc_hit, rbs_hit, wr_hit, wr_done;
         logic [1:0] step;
         logic [15:0] dec;
         assign sel_port = bus.addr == interval_timer_pkg::counter0_count_port + 8'(g);
         assign wr_hit = bus.wr && sel_port;
         assign rd_hit[g] = bus.rd && sel_port;
         assign cw_hit = is_cmd && bus.wdata[7:6] == 2'(g) && bus.wdata[5:4] != interval_timer_pkg::rw_latch;
         assign cl_hit = is_cmd && bus.wdata[7:6] == 2'(g) && bus.wdata[5:4] == interval_timer_pkg::rw_latch;
         assign rbc_hit = is_cmd && bus.wdata[7:6] == interval_timer_pkg::sel_readback
            && !bus.wdata[interval_timer_pkg::rb_count_n_bit] && bus.wdata[interval_timer_pkg::rb_cnt0_bit + g];
         assign rbs_hit = is_cmd && bus.wdata[7:6] == interval_timer_pkg::sel_readback
            && !bus.wdata[interval_timer_pkg::rb_status_n_bit] && bus.wdata[interval_timer_pkg::rb_cnt0_bit + g];
         // a write completes when the last byte of the format arrives
         assign wr_done = wr_hit && (rw_reg != interval_timer_pkg::rw_both || wlow_reg);
         assign step = (mode_reg[1:0] == 2'h3) ? 2'h2 : 2'h1;
         // down step in binary or decimal
         always_comb begin
            dec = cnt_reg - 16'(step);
            if (bcd_reg) begin
               dec = cnt_reg;
               for (int i = 0; i < int'(step); i++) begin
                  if (dec[3:0] != 4'h0) dec[3:0] = dec[3:0] - 4'h1;
                  else begin
                     dec[3:0] = 4'h9;
                     if (dec[7:4] != 4'h0) dec[7:4] = dec[7:4] - 4'h1;
                     else begin
                        dec[7:4] = 4'h9;
                        if (dec[11:8] != 4'h0) dec[11:8] = dec[11:8] - 4'h1;
                        else begin
                           dec[11:8] = 4'h9;
                           dec[15:12] = (dec[15:12] == 4'h0) ? 4'h9 : dec[15:12] - 4'h1;
                        end
                     end
                  end
               end
            end
         end
         // control word and count byte assembly
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               mode_reg <= 3'h0;
               rw_reg <= interval_timer_pkg::rw_low;
               bcd_reg <= 1'b0;
               init_reg <= 16'h0000;
               wlow_reg <= 1'b0;
            end else if (cw_hit) begin
               mode_reg <= bus.wdata[3:1];
               rw_reg <= bus.wdata[5:4];
               bcd_reg <= bus.wdata[interval_timer_pkg::cw_bcd_bit];
               wlow_reg <= 1'b0;
            end else if (wr_hit) begin
               case (rw_reg)
                  interval_timer_pkg::rw_low: init_reg <= {8'h00, bus.wdata};
                  interval_timer_pkg::rw_high: init_reg <= {bus.wdata, 8'h00};
                  default: begin
                     if (!wlow_reg) init_reg[7:0] <= bus.wdata;
                     else init_reg[15:8] <= bus.wdata;
                     wlow_reg <= !wlow_reg;
                  end
               endcase
            end
         end
         // counting, reload and output per mode
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt_reg <= 16'h0000;
               out_reg <= 1'b0;
               null_reg <= 1'b0;
               load_reg <= 1'b0;
               armed_reg <= 1'b0;
               gate_q <= 1'b0;
            end else begin
               // gate edges are judged tick to tick so a rise between ticks is not lost
               if (tick) gate_q <= gate[g];
               if (cw_hit) begin
                  out_reg <= (bus.wdata[3:1] == 3'h0 || bus.wdata[3:1] == 3'h1) ? 1'b0 : 1'b1;
                  armed_reg <= 1'b0;
                  load_reg <= 1'b0;
                  null_reg <= 1'b1;
               end else if (tick) begin
                  if (load_reg || (mode_reg[1:0] == 2'h1 && gate[g] && !gate_q)) begin
                     cnt_reg <= init_reg;
                     load_reg <= 1'b0;
                     null_reg <= 1'b0;
                     armed_reg <= 1'b1;
                  end else if (armed_reg) begin
                     case (mode_reg)
                        3'h0: begin
                           cnt_reg <= dec;
                           if (cnt_reg == 16'h0001) out_reg <= 1'b1;
                        end
                        3'h1: begin
                           cnt_reg <= dec;
                           out_reg <= (cnt_reg == 16'h0001);
                           if (cnt_reg == 16'h0001) armed_reg <= 1'b0;
                        end
                        3'h2, 3'h6: begin
                           out_reg <= (cnt_reg != 16'h0002);
                           cnt_reg <= (cnt_reg == 16'h0001) ? init_reg : dec;
                        end
                        3'h3, 3'h7: begin
                           if (cnt_reg <= 16'h0002) begin
                              out_reg <= !out_reg;
                              cnt_reg <= init_reg;
                           end else begin
                              cnt_reg <= dec;
                           end
                        end
                        3'h4, 3'h5: begin
                           cnt_reg <= dec;
                           out_reg <= (cnt_reg != 16'h0001);
                           if (cnt_reg == 16'h0001) armed_reg <= 1'b0;
                        end
                        default: cnt_reg <= dec;
                     endcase
                  end else if (mode_reg[1:0] != 2'h2 && mode_reg[1:0] != 2'h3) begin
                     out_reg <= mode_reg[2];
                  end
               end
               // a count write on a tick cycle keeps that tick, then the write wins
               if (wr_done) begin
                  load_reg <= 1'b1;
                  null_reg <= 1'b1;
                  if (mode_reg == 3'h0) out_reg <= 1'b0;
               end
            end
         end
         // count and status latches with read sequencing
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               latch_reg <= 16'h0000;
               status_reg <= 8'h00;
               cl_reg <= 1'b0;
               sl_reg <= 1'b0;
               rlow_reg <= 1'b0;
            end else if (cw_hit) begin
               cl_reg <= 1'b0;
               sl_reg <= 1'b0;
               rlow_reg <= 1'b0;
            end else begin
               if ((cl_hit || rbc_hit) && !cl_reg) begin
                  latch_reg <= cnt_reg;
                  cl_reg <= 1'b1;
               end
               if (rbs_hit && !sl_reg) begin
                  status_reg <= {out_reg, null_reg, rw_reg, mode_reg, bcd_reg};
                  sl_reg <= 1'b1;
               end
               if (rd_hit[g]) begin
                  if (sl_reg) sl_reg <= 1'b0;
                  else begin
                     if (rw_reg != interval_timer_pkg::rw_both || rlow_reg) cl_reg <= 1'b0;
                     if (rw_reg == interval_timer_pkg::rw_both) rlow_reg <= !rlow_reg;
                  end
               end
            end
         end
         // selected read byte; live count is taken as is
         always_comb begin
            logic [15:0] src;
            src = cl_reg ? latch_reg : cnt_reg;
            if (sl_reg) rbyte[g] = status_reg;
            else if (rw_reg == interval_timer_pkg::rw_high || (rw_reg == interval_timer_pkg::rw_both && rlow_reg))
               rbyte[g] = src[15:8];
            else rbyte[g] = src[7:0];
         end
         assign counter_out[g] = out_reg;
      end
   endgenerate

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 8'h00;
      end else if (rd_hit[0]) begin
         rdata_reg <= rbyte[0];
      end else if (rd_hit[1]) begin
         rdata_reg <= rbyte[1];
      end else if (rd_hit[2]) begin
         rdata_reg <= rbyte[2];
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign bus.rdata = rdata_reg;
endmodule
`default_nettype wire

// ===== design/interval_timer_host.sv
// host end: turns user byte requests into port cycles
`timescale 1ns/10ps
`default_nettype none
module interval_timer_host (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // user side
   input wire logic req_wr,
   input wire logic req_rd,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_wdata,
   output logic [7:0] rsp_data,
   output logic rsp_valid,
   // port side
   interval_timer_if.host bus
);
   logic [7:0] addr_reg, wdata_reg;
   logic wr_reg, rd_reg, pend_reg;
   // one registered port cycle per request; user keeps its own ordering
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_reg <= 8'h00;
         wdata_reg <= 8'h00;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
      end else begin
         wr_reg <= req_wr && !req_rd;
         rd_reg <= req_rd;
         if (req_wr || req_rd) begin
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
         end
      end
   end
   // capture read byte in the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_reg <= 1'b0;
         rsp_data <= 8'h00;
         rsp_valid <= 1'b0;
      end else begin
         pend_reg <= rd_reg;
         rsp_valid <= pend_reg;
         if (pend_reg) rsp_data <= bus.rdata;
      end
   end
   assign bus.addr = addr_reg;
   assign bus.wdata = wdata_reg;
   assign bus.wr = wr_reg;
   assign bus.rd = rd_reg;
endmodule
`default_nettype wire

// ===== dv/interval_timer_properties.sv
// port and output checks for the interval timer pair
`timescale 1ns/10ps
`default_nettype none
module interval_timer_properties (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // byte port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // timer outputs
   input wire logic system_timer_irq,
   input wire logic [2:0] counter_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [2:0] mode0_reg;
   logic cw0;
   // control word aimed at counter 0, latch commands excluded
   assign cw0 = wr && addr == 8'h43 && wdata[7:6] == 2'h0 && wdata[5:4] != 2'h0;
   // follow the programmed mode of counter 0
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode0_reg <= 3'h0;
      end else if (cw0) begin
         mode0_reg <= wdata[3:1];
      end
   end
   strobe_excl_a: assert property (!(wr && rd)) else $error("read and write strobes together");
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h0) else $error("read data outside slot");
   unmapped_rd_a: assert property (rd && (addr < 8'h40 || addr > 8'h43) |=> rdata == 8'h0)
      else $error("unmapped read not zero");
   irq_follow_a: assert property (system_timer_irq == counter_out[0]) else $error("irq differs");
   mode0_start_a: assert property (cw0 && wdata[3:1] == 3'h0 |-> ##2 !counter_out[0])
      else $error("mode 0 output not low");
   mode3_start_a: assert property (cw0 && wdata[3:1] == 3'h3 |-> ##2 counter_out[0])
      else $error("mode 3 output not high");
   mode0_hold_a: assert property (mode0_reg == 3'h0 && counter_out[0] && !wr && !$past(wr) && !$past(wr, 2)
      |=> counter_out[0]) else $error("mode 0 output dropped");
   low_pulse_a: assert property ((mode0_reg == 3'h2 || mode0_reg == 3'h4) && $fell(counter_out[0])
      |-> !counter_out[0] [*8] ##10 counter_out[0]) else $error("low pulse not one tick");
   cover property (rd && addr == 8'h40);
   cover property (mode0_reg == 3'h3 && $rose(counter_out[0]));
   cover property (mode0_reg == 3'h2 && $fell(counter_out[0]));
endmodule
`default_nettype wire

// ===== dv/legacy_interval_timer_tb.sv
// self-checking bench joining host end and timer end
`timescale 1ns/10ps
`default_nettype none
module legacy_interval_timer_tb;
   localparam int tk = interval_timer_pkg::tick_div;
   logic clk, arst_n, working_state, req_wr, req_rd, rsp_valid, system_timer_irq;
   logic [2:0] gate, counter_out;
   logic [7:0] req_addr, req_wdata, rsp_data;
   int error_cnt, compares, n;
   int cyc = 0;
   interval_timer_if bus_if();
   interval_timer u_interval_timer (.clk(clk), .arst_n(arst_n), .bus(bus_if), .working_state(working_state),
      .gate(gate), .system_timer_irq(system_timer_irq), .counter_out(counter_out));
   interval_timer_host u_interval_timer_host (.clk(clk), .arst_n(arst_n), .req_wr(req_wr), .req_rd(req_rd),
      .req_addr(req_addr), .req_wdata(req_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .bus(bus_if));
   interval_timer_properties u_interval_timer_properties (.clk(clk), .arst_n(arst_n), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
      .system_timer_irq(system_timer_irq), .counter_out(counter_out));
   task automatic end_of_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one-cycle user write request
   task automatic wr_port(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req_wr <= 1'b1;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req_wr <= 1'b0;
   endtask
   // one-cycle user read request, answer sampled mid-cycle
   task automatic rd_port(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req_rd <= 1'b1;
      req_addr <= a;
      @(posedge clk);
      req_rd <= 1'b0;
      for (int i = 0; i < 8 && rsp_valid !== 1'b1; i++) @(negedge clk);
      check("rsp_valid", rsp_valid, 1'b1);
      d = rsp_data;
   endtask
   // count cycles until an output reaches a level
   task automatic wait_out(input int c, input logic lvl, input int lim);
      n = 0;
      while (counter_out[c] !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic t_basic();
      logic [7:0] d;
      check("out after reset", counter_out, 3'h0);
      rd_port(8'h50, d);
      check("unmapped read", d, 8'h00);
   endtask
   task automatic t_square();
      wr_port(8'h43, 8'h36);
      wr_port(8'h40, 8'h10);
      wr_port(8'h40, 8'h00);
      wait_out(0, 1'b0, 4000);
      wait_out(0, 1'b1, 4000);
      check("square low", n, 8 * tk);
      wait_out(0, 1'b0, 4000);
      check("square high", n, 8 * tk);
   endtask
   task automatic t_mode0();
      wr_port(8'h43, 8'h30);
      wr_port(8'h40, 8'h05);
      wr_port(8'h40, 8'h00);
      repeat (2 * tk) @(negedge clk);
      check("mode0 early", counter_out[0], 1'b0);
      wait_out(0, 1'b1, 20 * tk);
      repeat (10 * tk) @(negedge clk);
      check("mode0 held", counter_out[0], 1'b1);
   endtask
   // program a counter, raise its gate (a retrigger in modes 1 and 5 only), measure the one-tick pulse
   task automatic t_pulse(input int c, input logic [7:0] cw, input logic idle);
      @(posedge clk);
      gate[c] <= 1'b0;
      wr_port(8'h43, cw);
      wr_port(8'h40 + 8'(c), 8'h40);
      wr_port(8'h40 + 8'(c), 8'h00);
      @(negedge clk);
      check("idle level", counter_out[c], idle);
      @(posedge clk);
      gate[c] <= 1'b1;
      wait_out(c, !idle, 3000);
      wait_out(c, idle, 100);
      check("pulse width", n, tk);
   endtask
   task automatic t_latch();
      logic [7:0] lo, hi, a, b, c, l2, h2;
      wr_port(8'h43, 8'h34);
      wr_port(8'h40, 8'h00);
      wr_port(8'h40, 8'h10);
      repeat (4 * tk) @(posedge clk);
      working_state <= 1'b0;
      rd_port(8'h40, lo);
      rd_port(8'h40, hi);
      wr_port(8'h43, 8'h00);
      working_state <= 1'b1;
      repeat (10 * tk) @(posedge clk);
      wr_port(8'h43, 8'h00);
      working_state <= 1'b0;
      rd_port(8'h40, a);
      rd_port(8'h42, b);
      rd_port(8'h40, c);
      check("latched count", {c, a}, {hi, lo});
      rd_port(8'h40, l2);
      rd_port(8'h40, h2);
      check("ticks run", ({hi, lo} - {h2, l2}) inside {[9:11]}, 1'b1);
   endtask
   task automatic t_readback();
      logic [7:0] a, lo, hi, l2, h2;
      wr_port(8'h43, 8'h75);
      wr_port(8'h41, 8'h00);
      wr_port(8'h41, 8'h20);
      wr_port(8'h43, 8'he4);
      working_state <= 1'b1;
      repeat (3 * tk) @(posedge clk);
      working_state <= 1'b0;
      wr_port(8'h43, 8'he4);
      rd_port(8'h41, a);
      check("first status", a, 8'hf5);
      wr_port(8'h43, 8'hc4);
      rd_port(8'h41, a);
      check("loaded status", a, 8'hb5);
      rd_port(8'h41, lo);
      rd_port(8'h41, hi);
      check("bcd count high", hi, 8'h19);
      rd_port(8'h41, l2);
      rd_port(8'h41, h2);
      check("live after latch", {h2, l2}, {hi, lo});
   endtask
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end
   initial begin
      arst_n = 1'b0;
      working_state = 1'b1;
      gate = 3'h7;
      req_wr = 1'b0;
      req_rd = 1'b0;
      req_addr = 8'h00;
      req_wdata = 8'h00;
      error_cnt = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_basic();
      t_square();
      t_mode0();
      t_pulse(0, 8'h34, 1'b1);
      t_pulse(0, 8'h38, 1'b1);
      t_pulse(1, 8'h72, 1'b0);
      t_pulse(2, 8'hba, 1'b1);
      t_latch();
      t_readback();
      end_of_test();
   end
endmodule
`default_nettype wire
